/* hdl/energy_pulse_pkg.sv */
// shared constants, types and arithmetic helpers for the reactive/apparent pulse block
// assumes a single 50 MHz clock and synchronous, active-high reset
package energy_pulse_pkg;
  localparam int PHASES = 3;
  localparam int PWR_W = 24;
  localparam int ACC_W = 41;
  localparam int EREG_W = 16;
  localparam logic [1:0] TICK_LAST = 2'h3;
  localparam int ACC_TOP_LSB = 25;
  localparam int HALF_FULL_BIT = 14;
  localparam int GAIN_FRAC = 12;
  localparam int LPF_SHIFT = 4;
  localparam int DFC_THRESH_W = 28;
  // connection select codes
  localparam logic [1:0] CONN_WYE = 2'h0;
  localparam logic [1:0] CONN_DELTA = 2'h1;
  localparam logic [1:0] CONN_TWO = 2'h2;
  // field positions
  localparam int CM_SUM_LSB = 2;
  localparam int CM_ABS_BIT = 5;
  localparam int CM_SIGN_ADJ_BIT = 6;
  localparam int WM_APPARENT_BIT = 7;
  localparam int LC_REACTIVE_BIT = 1;
  localparam int LC_CLEAR_READ_BIT = 6;
  // pulse timing
  localparam int CLK_HZ = 50_000_000;
  localparam int EQUAL_WIDTH_CYC = 64;
  localparam int LONG_PERIOD_MS = 180;
  localparam int FIXED_WIDTH_MS = 90;
  localparam int LONG_PERIOD_CYC = LONG_PERIOD_MS * (CLK_HZ / 1000);
  localparam int FIXED_WIDTH_CYC = FIXED_WIDTH_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    LC_OFF = 2'h0,
    LC_RUN = 2'h1
  } line_cycle_state_t;

  // x * (1 + g / 2^12), wraps like the hardware adder
  function automatic logic signed [23:0] apply_gain(input logic signed [23:0] x,
                                                    input logic signed [11:0] g);
    logic signed [35:0] p;
    p = x * g;
    return x + p[35:12];
  endfunction

  // voltage times current, scaled back to a power word
  function automatic logic signed [23:0] mul_top(input logic signed [15:0] v,
                                                 input logic signed [23:0] c);
    logic signed [39:0] p;
    p = v * c;
    return p[38:15];
  endfunction
endpackage

/* hdl/pulse_if.sv */
// carrier between the power summing logic and the pulse converter
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface pulse_if;
  logic sample_tick;
  logic signed [31:0] total;
  logic [11:0] numerator;
  logic [11:0] denominator;
  logic pin;
  modport src(output sample_tick, output total, output numerator, output denominator,
              input pin);
  modport conv(input sample_tick, input total, input numerator, input denominator,
               output pin);
endinterface

/* hdl/power_lowpass.sv */
// first-order low-pass filter for one power word, updated on the sample tick
// assumes din is already registered on ref_clk
`timescale 1ns/1ps
module power_lowpass #(
  parameter int WIDTH = 24,
  parameter int SHIFT = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // data
  input wire logic sample_tick,
  input wire logic signed [WIDTH-1:0] din,
  output logic signed [WIDTH-1:0] dout
);
  typedef struct packed {
    logic signed [WIDTH+SHIFT-1:0] acc;
  } lpf_state_t;
  lpf_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    // extra fraction bits keep small inputs from being lost in the shift
    if (sample_tick) begin
      st_next.acc = st_reg.acc + (WIDTH + SHIFT)'(din) - (st_reg.acc >>> SHIFT);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.acc[WIDTH+SHIFT-1:SHIFT];
endmodule

/* hdl/energy_to_pulse_converter.sv */
// converts total power to converter pulses and divides them down to the output pin
// assumes total and sample_tick come from logic on ref_clk
`timescale 1ns/1ps
module energy_to_pulse_converter #(
  parameter int LONG_PERIOD_CYC = energy_pulse_pkg::LONG_PERIOD_CYC,
  parameter int FIXED_WIDTH_CYC = energy_pulse_pkg::FIXED_WIDTH_CYC,
  parameter int THRESH_W = energy_pulse_pkg::DFC_THRESH_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // power in, pin out
  pulse_if.conv pif
);
  localparam logic [32:0] THRESH = 33'h1 << THRESH_W;
  typedef struct packed {
    logic [31:0] eacc;
    logic [12:0] frac;
    logic [23:0] dfc_cnt;
    logic [23:0] dfc_period;
    logic [23:0] pin_cnt;
    logic [23:0] width_cnt;
    logic pin;
  } dfc_state_t;
  dfc_state_t st_reg, st_next;
  logic dfc_fire, pin_fire, long_period;
  logic [31:0] mag;
  logic [32:0] e_sum;
  logic [12:0] f_sum, half_den;
  logic [35:0] w_prod;
  logic [23:0] width;
  logic [7:0] hi_len;
  logic eq_mode, refire;

  always_comb begin
    st_next = st_reg;
    dfc_fire = 1'b0;
    pin_fire = 1'b0;
    mag = pif.total[31] ? 32'(-pif.total) : 32'(pif.total);
    e_sum = {1'b0, st_reg.eacc} + {1'b0, mag};
    f_sum = st_reg.frac + {1'b0, pif.numerator};
    half_den = ({1'b0, pif.denominator} + 13'h1) >> 1;
    w_prod = st_reg.dfc_period * half_den[11:0];
    long_period = st_reg.pin_cnt > 24'(LONG_PERIOD_CYC);
    if (long_period) begin
      width = 24'(FIXED_WIDTH_CYC);
    end else if (pif.denominator > pif.numerator) begin
      width = (w_prod[35:24] != 12'h0) ? 24'hffffff : w_prod[23:0];
    end else begin
      width = 24'(energy_pulse_pkg::EQUAL_WIDTH_CYC);
    end
    if (width == 24'h0) begin
      width = 24'h1;
    end
    if (st_reg.dfc_cnt != 24'hffffff) begin
      st_next.dfc_cnt = st_reg.dfc_cnt + 24'h1;
    end
    if (st_reg.pin_cnt != 24'hffffff) begin
      st_next.pin_cnt = st_reg.pin_cnt + 24'h1;
    end
    if (pif.sample_tick) begin
      st_next.eacc = e_sum[31:0];
      if (e_sum >= THRESH) begin
        dfc_fire = 1'b1;
        st_next.eacc = 32'(e_sum - THRESH);
      end
    end
    // numerator/denominator divider: one pin pulse per den/num converter pulses
    if (dfc_fire) begin
      st_next.dfc_period = st_reg.dfc_cnt;
      st_next.dfc_cnt = 24'h0;
      st_next.frac = f_sum;
      if (pif.denominator != 12'h0 && f_sum >= {1'b0, pif.denominator}) begin
        pin_fire = 1'b1;
        st_next.frac = f_sum - {1'b0, pif.denominator};
        // num above den cannot be kept up with; cap the backlog
        if (st_next.frac >= {1'b0, pif.denominator}) begin
          st_next.frac = {1'b0, pif.denominator} - 13'h1;
        end
      end
    end
    if (pin_fire) begin
      st_next.pin_cnt = 24'h0;
      st_next.width_cnt = width - 24'h1;
      st_next.pin = 1'b1;
    end else if (st_reg.width_cnt != 24'h0) begin
      st_next.width_cnt = st_reg.width_cnt - 24'h1;
    end else begin
      st_next.pin = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pif.pin = st_reg.pin;

  // helper for the width check only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hi_len <= 8'h0;
      eq_mode <= 1'b0;
      refire <= 1'b0;
    end else begin
      hi_len <= !st_reg.pin ? 8'h0 : (hi_len == 8'hff ? hi_len : hi_len + 8'h1);
      if (pin_fire) begin
        eq_mode <= (pif.numerator == pif.denominator) && !long_period;
        refire <= st_reg.pin;
      end
    end
  end

  a_width_equal: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(st_reg.pin) && eq_mode && !refire |-> hi_len == 8'h40)
    else $error("equal divider pulse width is not 64 cycles");
  a_long_width: assert property (@(posedge ref_clk) disable iff (rst)
    pin_fire && long_period |=> st_reg.pin && st_reg.width_cnt == 24'(FIXED_WIDTH_CYC - 1))
    else $error("long period pulse width not fixed");
  a_pin_from_dfc: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st_reg.pin) |-> $past(dfc_fire) && st_reg.pin_cnt == 24'h0)
    else $error("pin pulse without converter pulse");
endmodule

/* hdl/reactive_apparent_energy_pulse.sv */
// per-phase reactive energy accumulation, apparent power and the reactive/apparent pulse pin
// assumes all inputs come from logic on ref_clk; config ports are held stable by the host
`timescale 1ns/1ps
module reactive_apparent_energy_pulse #(
  parameter int LONG_PERIOD_CYC = energy_pulse_pkg::LONG_PERIOD_CYC,
  parameter int FIXED_WIDTH_CYC = energy_pulse_pkg::FIXED_WIDTH_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // per-phase waveforms and rms values
  input wire logic [2:0][15:0] volt,
  input wire logic [2:0][15:0] curr_shift,
  input wire logic [2:0][15:0] vrms,
  input wire logic [2:0][15:0] irms,
  input wire logic [2:0] active_negative,
  // gains
  input wire logic [2:0][11:0] current_gain,
  input wire logic [2:0][11:0] reactive_gain,
  input wire logic [2:0][11:0] apparent_gain,
  // configuration
  input wire logic [1:0] connection_select,
  input wire logic [7:0] computation_mode_reg,
  input wire logic [7:0] waveform_mode_reg,
  input wire logic [7:0] line_cycle_mode_reg,
  input wire logic [15:0] zero_crossing_count,
  input wire logic [7:0] reactive_energy_divider,
  input wire logic [11:0] pulse_numerator,
  input wire logic [11:0] pulse_denominator,
  input wire logic reactive_half_full_mask,
  // events
  input wire logic zero_crossing,
  input wire logic [2:0] energy_read,
  input wire logic irq_ack,
  // results
  output logic [15:0] phase_a_reactive_energy,
  output logic [15:0] phase_b_reactive_energy,
  output logic [15:0] phase_c_reactive_energy,
  output logic reactive_pulse_pin,
  output logic irq_n
);
  localparam int PHASES = energy_pulse_pkg::PHASES;
  localparam int TOP = energy_pulse_pkg::ACC_TOP_LSB;
  localparam int HF = energy_pulse_pkg::HALF_FULL_BIT;

  typedef struct packed {
    logic [1:0] tick_cnt;
    logic tick;
    energy_pulse_pkg::line_cycle_state_t lc;
    logic [15:0] zc_cnt;
    logic [2:0][23:0] q_inst;
    logic [2:0][23:0] s_inst;
    logic [2:0][40:0] acc;
    logic [2:0][15:0] energy;
    logic signed [31:0] total;
    logic irq_n;
  } main_state_t;
  main_state_t st_reg, st_next;

  logic [2:0][23:0] cur_g, q_sel, q_g, q_div, s_gain_raw, s_g;
  // filter outputs arrive through instance ports, one element per phase
  wire logic [2:0][23:0] q_lp, s_lp;
  logic [2:0][31:0] s_prod;
  logic [23:0] q_a_delta, q_c_delta, qg_a;
  logic [40:0] full, add;
  logic signed [31:0] q_total, s_total;
  logic [23:0] q_term;
  logic lc_en, zc_done, clear_acc, hf_change;
  pulse_if pif();

  // per-phase arithmetic, recomputed every clock
  always_comb begin
    for (int p = 0; p < PHASES; p++) begin
      cur_g[p] = energy_pulse_pkg::apply_gain({{8{curr_shift[p][15]}}, curr_shift[p]},
                                              current_gain[p]);
      q_g[p] = energy_pulse_pkg::apply_gain(q_lp[p], reactive_gain[p]);
      // integer division drops the remainder each sample; a small slow-down error
      q_div[p] = (reactive_energy_divider > 8'h01) ?
                 24'($signed(q_g[p]) / $signed({1'b0, reactive_energy_divider})) :
                 q_g[p];
      s_prod[p] = vrms[p] * irms[p];
      s_gain_raw[p] = energy_pulse_pkg::apply_gain(s_lp[p], apparent_gain[p]);
      // no offset term: rms offsets already handled upstream
      s_g[p] = s_gain_raw[p][23] ? 24'h0 : s_gain_raw[p];
    end
    q_a_delta = energy_pulse_pkg::mul_top(volt[0], cur_g[0] - cur_g[1]);
    q_c_delta = energy_pulse_pkg::mul_top(volt[2], cur_g[2] - cur_g[1]);
    for (int p = 0; p < PHASES; p++) begin
      q_sel[p] = energy_pulse_pkg::mul_top(volt[p], cur_g[p]);
    end
    // reserved code falls back to the wye products
    case (connection_select)
      energy_pulse_pkg::CONN_DELTA: begin
        q_sel[0] = q_a_delta;
        q_sel[1] = 24'h0;
        q_sel[2] = q_c_delta;
      end
      energy_pulse_pkg::CONN_TWO: begin
        q_sel[0] = q_a_delta;
        q_sel[1] = 24'h0;
      end
      default: begin
      end
    endcase
  end

  assign qg_a = q_g[0];

  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    power_lowpass #(
      .WIDTH(energy_pulse_pkg::PWR_W),
      .SHIFT(energy_pulse_pkg::LPF_SHIFT)
    ) u_q_lpf (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_tick(st_reg.tick),
      .din(st_reg.q_inst[p]),
      .dout(q_lp[p])
    );
    power_lowpass #(
      .WIDTH(energy_pulse_pkg::PWR_W),
      .SHIFT(energy_pulse_pkg::LPF_SHIFT)
    ) u_s_lpf (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_tick(st_reg.tick),
      .din(st_reg.s_inst[p]),
      .dout(s_lp[p])
    );
  end

  always_comb begin
    st_next = st_reg;
    lc_en = line_cycle_mode_reg[energy_pulse_pkg::LC_REACTIVE_BIT];
    zc_done = 1'b0;
    clear_acc = 1'b0;
    hf_change = 1'b0;
    full = '0;
    add = '0;
    q_term = '0;
    q_total = '0;
    s_total = '0;
    st_next.tick = (st_reg.tick_cnt == energy_pulse_pkg::TICK_LAST);
    st_next.tick_cnt = st_reg.tick_cnt + 2'h1;
    for (int p = 0; p < PHASES; p++) begin
      st_next.q_inst[p] = q_sel[p];
      st_next.s_inst[p] = {1'b0, s_prod[p][31:9]};
    end
    case (st_reg.lc)
      energy_pulse_pkg::LC_OFF: begin
        if (lc_en) begin
          st_next.lc = energy_pulse_pkg::LC_RUN;
          st_next.zc_cnt = 16'h0;
          clear_acc = 1'b1;
        end
      end
      energy_pulse_pkg::LC_RUN: begin
        if (!lc_en) begin
          st_next.lc = energy_pulse_pkg::LC_OFF;
        end else if (zero_crossing) begin
          if (17'(st_reg.zc_cnt) + 17'h1 >= {1'b0, zero_crossing_count}) begin
            zc_done = 1'b1;
            st_next.zc_cnt = 16'h0;
          end else begin
            st_next.zc_cnt = st_reg.zc_cnt + 16'h1;
          end
        end
      end
      default: begin
        st_next.lc = energy_pulse_pkg::LC_OFF;
      end
    endcase
    for (int p = 0; p < PHASES; p++) begin
      add = st_reg.tick ? {{17{q_div[p][23]}}, q_div[p]} : 41'h0;
      full = st_reg.acc[p] + add;
      if (zc_done) begin
        st_next.energy[p] = full[40:TOP];
        st_next.acc[p] = 41'h0;
      end else if (clear_acc) begin
        st_next.acc[p] = 41'h0;
      end else if (energy_read[p] && st_reg.lc == energy_pulse_pkg::LC_OFF && !lc_en &&
                   line_cycle_mode_reg[energy_pulse_pkg::LC_CLEAR_READ_BIT]) begin
        // a sample landing with the read is kept, not lost
        st_next.acc[p] = add;
      end else begin
        st_next.acc[p] = full;
      end
      // top 16 bits wrap from 0x7fff to 0x8000 like a signed counter
      if (st_next.lc == energy_pulse_pkg::LC_OFF) begin
        st_next.energy[p] = st_next.acc[p][40:TOP];
      end
      hf_change = hf_change | (st_next.energy[p][HF] ^ st_reg.energy[p][HF]);
      q_term = q_g[p];
      if (computation_mode_reg[energy_pulse_pkg::CM_SIGN_ADJ_BIT] && active_negative[p]) begin
        q_term = 24'h0 - q_g[p];
      end
      if (computation_mode_reg[energy_pulse_pkg::CM_SUM_LSB + p]) begin
        q_total = q_total + {{8{q_term[23]}}, q_term};
        s_total = s_total + {8'h0, s_g[p]};
      end
    end
    st_next.total = waveform_mode_reg[energy_pulse_pkg::WM_APPARENT_BIT] ?
                    s_total : q_total;
    // set wins over the acknowledge
    if (reactive_half_full_mask && hf_change) begin
      st_next.irq_n = 1'b0;
    end else if (irq_ack) begin
      st_next.irq_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.irq_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pif.sample_tick = st_reg.tick;
  assign pif.total = st_reg.total;
  assign pif.numerator = pulse_numerator;
  assign pif.denominator = pulse_denominator;

  energy_to_pulse_converter #(
    .LONG_PERIOD_CYC(LONG_PERIOD_CYC),
    .FIXED_WIDTH_CYC(FIXED_WIDTH_CYC),
    .THRESH_W(energy_pulse_pkg::DFC_THRESH_W)
  ) u_dfc (
    .ref_clk(ref_clk),
    .rst(rst),
    .pif(pif)
  );

  assign phase_a_reactive_energy = st_reg.energy[0];
  assign phase_b_reactive_energy = st_reg.energy[1];
  assign phase_c_reactive_energy = st_reg.energy[2];
  assign reactive_pulse_pin = pif.pin;
  assign irq_n = st_reg.irq_n;

  a_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.tick |=> !st_reg.tick [*3] ##1 st_reg.tick)
    else $error("sample tick not every four clocks");
  a_conn_b_zero: assert property (@(posedge ref_clk) disable iff (rst)
    connection_select == energy_pulse_pkg::CONN_DELTA |=> st_reg.q_inst[1] == 24'h0)
    else $error("phase b product not zero in delta mode");
  a_energy_live: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.lc == energy_pulse_pkg::LC_OFF |-> st_reg.energy[0] == st_reg.acc[0][40:TOP])
    else $error("energy register is not the accumulator top");
  a_div_bypass: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.tick && reactive_energy_divider < 8'h02 && st_reg.lc == energy_pulse_pkg::LC_RUN &&
    lc_en && !zero_crossing
    |=> st_reg.acc[0] == $past(st_reg.acc[0]) + {{17{$past(qg_a[23])}}, $past(qg_a)})
    else $error("undivided sample not accumulated");
  a_zero_crossing_count_hold: assert property (@(posedge ref_clk) disable iff (rst)
    st_reg.lc == energy_pulse_pkg::LC_RUN && lc_en && !zc_done |=> $stable(st_reg.energy))
    else $error("energy changed inside a line-cycle window");
  a_irq_half: assert property (@(posedge ref_clk) disable iff (rst)
    $past(reactive_half_full_mask) && $changed(st_reg.energy[1][HF]) |-> !st_reg.irq_n)
    else $error("half-full change did not raise the interrupt");
  a_apparent_pos: assert property (@(posedge ref_clk) disable iff (rst)
    $past(waveform_mode_reg[energy_pulse_pkg::WM_APPARENT_BIT]) |-> !st_reg.total[31])
    else $error("apparent total went negative");
  a_sum_none: assert property (@(posedge ref_clk) disable iff (rst)
    computation_mode_reg[4:2] == 3'h0 |=> st_reg.total == 32'h0)
    else $error("total nonzero with no phase selected");
  // phases a and b summed, only b flagged negative: b enters with its sign flipped
  a_sign_adjust: assert property (@(posedge ref_clk) disable iff (rst)
    computation_mode_reg[energy_pulse_pkg::CM_SIGN_ADJ_BIT] &&
    computation_mode_reg[4:2] == 3'h3 && active_negative[1:0] == 2'h2 &&
    !waveform_mode_reg[energy_pulse_pkg::WM_APPARENT_BIT]
    |=> st_reg.total == $past(32'($signed(q_g[0])) - 32'($signed(q_g[1]))))
    else $error("sign adjust did not negate phase b");
endmodule

/* testbench/pulse_counter.sv */
// partner model: external counter on the pulse pin, tallies pulses and times each width
// assumes the pin is registered on ref_clk
`timescale 1ns/1ps
module pulse_counter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // observed pin
  input wire logic pin,
  // tallies
  output int unsigned pulse_total,
  output int unsigned width_last
);
  int unsigned run_len;
  logic pin_reg;
  // width lands only on the falling edge, so a pulse cut short by reset is never reported
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pulse_total <= 0;
      width_last <= 0;
      run_len <= 0;
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin;
      run_len <= pin ? run_len + 1 : 0;
      if (pin && !pin_reg) begin
        pulse_total <= pulse_total + 1;
      end
      if (!pin && pin_reg) begin
        width_last <= run_len;
      end
    end
  end
endmodule

/* testbench/testbench.sv */
// self-checking bench for the reactive/apparent energy and pulse block
// assumes a 50 MHz ref_clk; long pulse figures shrunk to 400/200 cycles
`timescale 1ns/1ps
module testbench;
  logic ref_clk;
  logic rst;
  logic [2:0][15:0] volt, curr_shift, vrms, irms;
  logic [2:0] active_negative, energy_read;
  logic [2:0][11:0] current_gain, reactive_gain, apparent_gain;
  logic [1:0] connection_select;
  logic [7:0] computation_mode_reg, waveform_mode_reg, line_cycle_mode_reg;
  logic [15:0] zero_crossing_count;
  logic [7:0] reactive_energy_divider;
  logic [11:0] pulse_numerator, pulse_denominator;
  logic reactive_half_full_mask, zero_crossing, irq_ack, reactive_pulse_pin, irq_n;
  logic [15:0] phase_a_reactive_energy, phase_b_reactive_energy, phase_c_reactive_energy;
  int unsigned pulse_total, width_last, got, cnt0;
  int err_total, n_checks;
  logic signed [15:0] a_full, a_frozen;

  reactive_apparent_energy_pulse #(.LONG_PERIOD_CYC(400), .FIXED_WIDTH_CYC(200)) DUT (
    .ref_clk(ref_clk), .rst(rst), .volt(volt), .curr_shift(curr_shift), .vrms(vrms),
    .irms(irms), .active_negative(active_negative), .current_gain(current_gain),
    .reactive_gain(reactive_gain), .apparent_gain(apparent_gain),
    .connection_select(connection_select), .computation_mode_reg(computation_mode_reg),
    .waveform_mode_reg(waveform_mode_reg), .line_cycle_mode_reg(line_cycle_mode_reg),
    .zero_crossing_count(zero_crossing_count),
    .reactive_energy_divider(reactive_energy_divider), .pulse_numerator(pulse_numerator),
    .pulse_denominator(pulse_denominator), .reactive_half_full_mask(reactive_half_full_mask),
    .zero_crossing(zero_crossing), .energy_read(energy_read), .irq_ack(irq_ack),
    .phase_a_reactive_energy(phase_a_reactive_energy),
    .phase_b_reactive_energy(phase_b_reactive_energy),
    .phase_c_reactive_energy(phase_c_reactive_energy),
    .reactive_pulse_pin(reactive_pulse_pin), .irq_n(irq_n));

  pulse_counter counter (.ref_clk(ref_clk), .rst(rst), .pin(reactive_pulse_pin),
    .pulse_total(pulse_total), .width_last(width_last));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic run(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    run(3);
    rst = 1'b0;
  endtask

  // pin pulses seen by the counter over n cycles
  task automatic window(input int n);
    cnt0 = pulse_total;
    run(n);
    got = pulse_total - cnt0;
  endtask

  // energy words drift by truncation, so ratios are judged with a tolerance
  function automatic logic near(input logic signed [15:0] a, input logic signed [15:0] b,
                                input int tol);
    return (a >= b - tol) && (a <= b + tol);
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #(90000 * 20);
    err_total++;
    close_out();
  end

  initial begin
    err_total = 0;
    n_checks = 0;
    rst = 1'b1;
    {volt, curr_shift, vrms, irms, active_negative, energy_read} = '0;
    current_gain = {3{12'h7ff}};
    reactive_gain = {12'h800, 12'h7ff, 12'h7ff};
    apparent_gain = '0;
    {connection_select, computation_mode_reg, waveform_mode_reg} = '0;
    {line_cycle_mode_reg, zero_crossing_count, reactive_energy_divider} = '0;
    pulse_numerator = 12'h001;
    pulse_denominator = 12'h001;
    {zero_crossing, irq_ack} = '0;
    reactive_half_full_mask = 1'b1;
    void'($urandom(86344));
    do_reset();
    // random waveforms, two-element modes keep phase b out of the sum
    for (int k = 0; k < 4; k++) begin
      connection_select = k[0] ? 2'h2 : 2'h1;
      volt = 48'({$urandom(), $urandom()});
      curr_shift = 48'({$urandom(), $urandom()});
      run(300);
      check("phase b energy", 32'(phase_b_reactive_energy), 32'h0);
    end
    do_reset();
    connection_select = 2'h0;
    volt = {3{16'h7fff}};
    curr_shift = {16'h7fff, 16'h8001, 16'h7fff};
    run(20000);
    a_full = phase_a_reactive_energy;
    check("phase a sign", 32'($signed(phase_a_reactive_energy) > 0), 32'h1);
    check("phase b mirror", 32'(near(-phase_b_reactive_energy, a_full, 1)), 32'h1);
    check("phase c gain", 32'(near(phase_c_reactive_energy * 3, a_full, 3)), 32'h1);
    // phase b going negative flips bit 14 of its register from 0 to 1
    check("irq set", 32'(irq_n), 32'h0);
    irq_ack = 1'b1;
    run(1);
    irq_ack = 1'b0;
    run(1);
    check("irq released", 32'(irq_n), 32'h1);
    zero_crossing_count = 16'h0002;
    line_cycle_mode_reg = 8'h02; // clear-on-read stays low
    run(10);
    a_frozen = phase_a_reactive_energy;
    run(2000);
    check("frozen energy", 32'(phase_a_reactive_energy), 32'(a_frozen));
    repeat (2) begin
      zero_crossing = 1'b1;
      run(1);
      zero_crossing = 1'b0;
      run(500);
    end
    a_frozen = phase_a_reactive_energy;
    check("line total", 32'(a_frozen < a_full && a_frozen > 0), 32'h1);
    run(600);
    check("line hold", 32'(phase_a_reactive_energy), 32'(a_frozen));
    line_cycle_mode_reg = 8'h00;
    do_reset();
    reactive_energy_divider = 8'h02;
    // a plus b nearly cancel in a signed sum; flipping b doubles the total instead
    computation_mode_reg = 8'h6c; // active magnitude bit set with sign-adjust
    active_negative = 3'h2;
    window(20000);
    check("sign adjust rate", 32'(got inside {[2:3]}), 32'h1);
    check("divided energy", 32'(near(phase_a_reactive_energy * 2, a_full, 2)), 32'h1);
    line_cycle_mode_reg = 8'h40;
    energy_read = 3'h1;
    run(1);
    energy_read = 3'h0;
    run(1);
    check("clear on read", 32'(phase_a_reactive_energy), 32'h0);
    line_cycle_mode_reg = 8'h00;
    do_reset();
    reactive_energy_divider = 8'h00;
    {volt, curr_shift} = '0;
    vrms = {3{16'hffff}};
    irms = {3{16'hffff}};
    computation_mode_reg = 8'h04;
    window(3000);
    check("reactive idle", got, 0);
    waveform_mode_reg = 8'h80;
    computation_mode_reg = 8'h00;
    window(3000);
    check("no phase summed", got, 0);
    computation_mode_reg = 8'h04;
    run(2500);
    window(2560);
    check("equal divider rate", 32'(got inside {[19:21]}), 32'h1);
    check("equal width", width_last, 64);
    apparent_gain = {12'h0, 12'h0, 12'h800};
    run(600);
    window(2560);
    check("apparent gain rate", 32'(got inside {[9:11]}), 32'h1);
    apparent_gain = '0;
    pulse_denominator = 12'h002;
    run(1000);
    check("half den width", 32'(width_last inside {[124:136]}), 32'h1);
    window(2560);
    check("half den rate", 32'(got inside {[9:11]}), 32'h1);
    pulse_denominator = 12'h004;
    run(2000);
    check("long period width", width_last, 200);
    irq_ack = 1'b1;
    run(1);
    irq_ack = 1'b0;
    run(2);
    check("irq after ack", 32'(irq_n), 32'h1);
    close_out();
  end
endmodule
